// file: verification/frbw_host_model.sv
// Model of the host processors and the real-time clock facing the boot supervisor.
`timescale 1ns/1ns

module frbw_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_hold,
    input  wire logic        i_slow,
    input  wire logic [31:0] i_rtc_now,
    input  wire logic        i_sys_rst,
    input  wire logic        i_async_rst,
    input  wire logic        i_rtc_read,
    output logic             o_host_in_reset,
    output logic [31:0]      o_rtc_time,
    output logic             o_rtc_valid
);
    logic [2:0] tail = 3'h0;  // Cycles the host stays in reset after a pulse.
    logic [3:0] lag  = 4'h0;  // Cycles left before the clock chip answers.

    ////////////////////////////////////////////////////////////////////////
    // Any reset pulse holds the processors in hard reset for a while.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_async_rst) begin
            tail <= 3'h4;
        end else if (tail != 3'h0) begin
            tail <= tail - 3'h1;
        end
    end
    assign o_host_in_reset = i_hold || i_sys_rst || i_async_rst || (tail != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // The clock chip answers promptly or slowly; a stale bus never shows the old value.
    always_ff @(posedge i_clk) begin
        o_rtc_valid <= 1'b0;
        if (i_rtc_read) begin
            lag <= i_slow ? 4'h6 : 4'h1;
        end else if (lag == 4'h1) begin
            o_rtc_valid <= 1'b1;
            lag <= 4'h0;
        end else if (lag != 4'h0) begin
            lag <= lag - 4'h1;
        end
    end
    assign o_rtc_time = o_rtc_valid ? i_rtc_now : ~i_rtc_now;
endmodule

// file: verification/tb.sv
// Self-checking bench for the boot supervisor.
`timescale 1ns/1ns

module tb;
    logic        clk = 1'b0;       // Core clock, 50 ns period.
    logic        rst = 1'b1;       // Synchronous reset.
    logic        halt_n = 1'b1;    // Reset-stage watchdog halt pin.
    logic        hold = 1'b1;      // Host kept in hard reset by the bench.
    logic        slow = 1'b1;      // Clock chip answers slowly.
    logic        wd_load = 1'b0;   // Self-test watchdog load strobe.
    logic [15:0] wd_secs = 16'h0;  // Self-test watchdog load value.
    logic        wd_en = 1'b0;     // Self-test watchdog enable.
    logic        dis_req = 1'b0;   // Processor disable request.
    logic [1:0]  dis_idx = 2'h0;   // Processor to disable.
    logic [3:0]  present = 4'hf;   // Installed processors.
    logic        set_t = 1'b0;     // Set-time strobe.
    logic [31:0] set_val = 32'h0;  // Set-time value.
    logic        get_t = 1'b0;     // Get-time strobe.
    logic [31:0] rtc_now = 32'h5a5a_0100;
    logic        in_rst, rtc_valid, rtc_read, get_valid, sys_rst, async_rst, speaker, halted;
    logic [31:0] rtc_time, cur_time;
    logic [3:0]  mask;
    logic [1:0]  boot;
    int          n_fail = 0;       // Mismatches seen.
    int          checks = 0;       // Comparisons made.

    initial begin
        forever #25 clk = ~clk;
    end

    // Counts are shortened so that one second is twenty cycles.
    frbw_top #(.CYC_PER_SEC(20), .BEEP_ON_CYC(4), .BEEP_OFF_CYC(4)) uut (
        .I_CORE_CLK(clk), .I_RST(rst), .i_reset_watchdog_halt_n(halt_n), .i_host_in_reset(in_rst),
        .i_boot_self_test_wd_load(wd_load), .i_boot_self_test_wd_secs(wd_secs), .i_boot_self_test_wd_enable(wd_en),
        .i_disable_req(dis_req), .i_disable_idx(dis_idx), .i_proc_present(present),
        .i_set_time(set_t), .i_set_time_val(set_val), .i_get_time(get_t), .i_rtc_time(rtc_time),
        .i_rtc_valid(rtc_valid), .o_rtc_read(rtc_read), .o_get_time_valid(get_valid), .o_time(cur_time),
        .o_proc_disable(mask), .o_bootstrap_processor(boot), .o_system_reset(sys_rst),
        .o_async_system_reset(async_rst), .o_speaker(speaker), .o_halt(halted));

    frbw_host_model host (
        .i_clk(clk), .i_hold(hold), .i_slow(slow), .i_rtc_now(rtc_now), .i_sys_rst(sys_rst),
        .i_async_rst(async_rst), .i_rtc_read(rtc_read), .o_host_in_reset(in_rst),
        .o_rtc_time(rtc_time), .o_rtc_valid(rtc_valid));

    ////////////////////////////////////////////////////////////////////////
    // Closing report; every path that ends the run comes here.
    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares a value against its expectation.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Selects one event output by number.
    function automatic logic pick(input int s);
        case (s)
            0: return sys_rst;
            1: return async_rst;
            2: return speaker;
            3: return halted;
            4: return rtc_valid;
            default: return get_valid;
        endcase
    endfunction

    // Waits lo to hi cycles for an event; a hang ends the run.
    task automatic wait_hi(input int s, input int lo, input int hi);
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pick(s) !== 1'b1 && n < hi);
        checks++;
        if (pick(s) !== 1'b1 || n < lo) begin
            n_fail++;
            $display("mismatch t=%0t event %0d after %0d cycles", $time, s, n);
            if (pick(s) !== 1'b1) begin
                print_verdict();
            end
        end
    endtask

    // Checks that an event stays away for a number of cycles.
    task automatic wait_none(input int s, input int cyc);
        int hits = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (pick(s) === 1'b1) begin
                hits++;
            end
        end
        chk_val(hits, 0, "unexpected event");
    endtask

    // Holds reset for two edges with the host in hard reset.
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        hold <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    // One disable request, sampled on a single edge.
    task automatic req(input logic [1:0] idx);
        @(posedge clk);
        dis_req <= 1'b1;
        dis_idx <= idx;
        @(posedge clk);
        dis_req <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values, then the timestamp is loaded from the slow clock chip.
    task automatic t_startup();
        do_reset();
        #1;
        chk_val(mask, 0, "mask");
        chk_val(boot, 0, "bootstrap");
        wait_hi(4, 0, 20);
        @(posedge clk);
        #1;
        chk_val(cur_time, rtc_now, "time from clock chip");
    endtask

    // The timestamp advances by one every twenty cycles and not sooner.
    task automatic t_tick();
        logic [31:0] v = cur_time;
        int          n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cur_time === v && n < 25);
        chk_val(cur_time !== v, 1, "tick seen");
        v = cur_time;
        repeat (19) @(posedge clk);
        #1;
        chk_val(cur_time, v, "time held");
        @(posedge clk);
        #1;
        chk_val(cur_time, v + 32'h1, "time step");
    endtask

    // Set-time loads the counter, get-time answers the next cycle.
    task automatic t_time();
        @(posedge clk);
        set_t <= 1'b1;
        set_val <= 32'h1234_5678;
        @(posedge clk);
        set_t <= 1'b0;
        get_t <= 1'b1;
        #1;
        chk_val(cur_time, 32'h1234_5678, "set time");
        @(posedge clk);
        get_t <= 1'b0;
        #1;
        chk_val(get_valid, 1, "get valid");
    endtask

    // Unhalted reset watchdog rotates the bootstrap role until none is left.
    task automatic t_cycle();
        @(posedge clk);
        hold <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wait_hi(0, 75, 140);
            chk_val(mask, (32'h1 << (k + 1)) - 32'h1, "failed processor");
            chk_val(boot, k + 1, "next bootstrap");
            repeat (16) @(posedge clk);
        end
        wait_hi(2, 75, 150);
        chk_val(mask, 32'hf, "all failed");
        do_reset();
        #1;
        chk_val(mask, 0, "mask after reset");
        chk_val(boot, 0, "bootstrap after reset");
    endtask

    // Host halts the reset watchdog in time; no reset follows.
    task automatic t_halt_line();
        @(posedge clk);
        hold <= 1'b0;
        repeat (20) @(posedge clk);
        halt_n <= 1'b0;
        wait_none(0, 200);
    endtask

    // Disable requests: the bootstrap moves, one inside a pulse is ignored, the last halts.
    task automatic t_disable();
        @(posedge clk);
        present <= 4'h7;
        repeat (5) @(posedge clk);
        req(2'h0);
        wait_hi(0, 0, 3);
        chk_val(boot, 1, "moved bootstrap");
        req(2'h2);
        repeat (25) @(posedge clk);
        #1;
        chk_val(mask, 32'h1, "ignored in pulse");
        req(2'h2);
        wait_hi(0, 0, 3);
        chk_val(mask, 32'h5, "disabled pair");
        repeat (30) @(posedge clk);
        req(2'h1);
        wait_hi(3, 0, 3);
        wait_hi(2, 0, 20);
        do_reset();
    endtask

    // Self-test watchdog left running expires; disabled in time it stays quiet.
    task automatic t_boot_self_test();
        @(posedge clk);
        hold <= 1'b0;
        halt_n <= 1'b1;
        present <= 4'hf;
        wd_load <= 1'b1;
        wd_secs <= 16'h3;
        wd_en <= 1'b1;
        @(posedge clk);
        wd_load <= 1'b0;
        halt_n <= 1'b0;
        wait_hi(1, 35, 75);
        @(posedge clk);
        wd_en <= 1'b0;
        repeat (30) @(posedge clk);
        wd_load <= 1'b1;
        wd_en <= 1'b1;
        @(posedge clk);
        wd_load <= 1'b0;
        repeat (20) @(posedge clk);
        wd_en <= 1'b0;
        wait_none(1, 120);
    endtask

    initial begin
        t_startup();
        t_tick();
        t_time();
        t_cycle();
        t_halt_line();
        t_disable();
        t_boot_self_test();
        print_verdict();
    end
endmodule

// file: verilog/frbw_cfg.svh
// Timing constants and field widths for the boot watchdog block.
`ifndef FRBW_CFG_SVH
`define FRBW_CFG_SVH

// Core clock rate in hertz.
`define FRBW_CLK_HZ            20000000
// Nominal reset-stage watchdog timeout in seconds.
`define FRBW_RST_WD_SEC        5
// Self-test-stage watchdog timeout the host is expected to load, in minutes.
`define FRBW_BOOT_SELF_TEST_WD_MIN       6
// Seconds between periodic real-time clock re-reads.
`define FRBW_RTC_RESYNC_SEC    64
// Width of the timestamp counter in bits (four bytes).
`define FRBW_TS_W              32
// Width of a watchdog count in seconds.
`define FRBW_WD_W              16
// Number of processors supervised.
`define FRBW_NPROC             4
// Width of a processor index.
`define FRBW_PIDX_W            2
// Width of the reset pulse in core cycles.
`define FRBW_RST_PULSE_CYC     16
// Beep on and off lengths in cycles.
`define FRBW_BEEP_ON_CYC       4000000
`define FRBW_BEEP_OFF_CYC      4000000

`endif

// file: verilog/frbw_pkg.sv
// Types shared by the boot watchdog block.
package frbw_pkg;
    // Sequencer states of the boot supervisor.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_RESET,
        ST_HALT
    } frbw_state_t;
endpackage

// file: verilog/frbw_tick.sv
// Divider that produces a one-cycle pulse once per second.
`timescale 1ns/1ns
`include "frbw_cfg.svh"

module frbw_tick #(
    parameter int CYC_PER_SEC = `FRBW_CLK_HZ
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_tick
);
    // Cycle counter within the current second.
    logic [24:0] cnt;

    // Count up and fire the tick on the last cycle of each second.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt    <= 25'h0;
            o_tick <= 1'b0;
        end else if (cnt == 25'(CYC_PER_SEC - 1)) begin
            cnt    <= 25'h0;
            o_tick <= 1'b1;
        end else begin
            cnt    <= cnt + 25'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

// file: verilog/frbw_top.sv
// Fault-resilient boot supervisor: two watchdogs, processor cycling and timestamp.
`timescale 1ns/1ns
`include "frbw_cfg.svh"

// Functional notes
// R1: Reset-stage watchdog starts at hard-reset exit, 5s.
// R2: Host halts reset watchdog by deasserting halt line.
// R3: Reset expiry resets system, disables failed processor.
// R4: Keep rotating bootstrap until reset watchdog disabled.
// R5: Beep when no working processor remains.
// R6: Full cycling restarts after every power reset.
// R7: Host loads self-test watchdog about six minutes.
// R8: Host enables self-test watchdog before halting reset one.
// R9: Host disables self-test watchdog before option firmware.
// R10: Host disables it before long memory test.
// R11: Self-test watchdog expiry issues asynchronous system reset.
// R12: Processor disable request resets system and disables; code acts on a request only in ST_RUN.
// R13: No alternate bootstrap: beep and halt; else reset.
// R14: Four-byte timestamp increments once per second.
// R15: Timestamp read by get, loaded by set command.
// R16: Load timestamp from RTC at start, resync periodically.
// R17: Watchdogs tick per second, expire with one pulse.
module frbw_top #(
    parameter int CYC_PER_SEC   = `FRBW_CLK_HZ,
    parameter int BEEP_ON_CYC   = `FRBW_BEEP_ON_CYC,
    parameter int BEEP_OFF_CYC  = `FRBW_BEEP_OFF_CYC
) (
    input  wire logic                     I_CORE_CLK,
    input  wire logic                     I_RST,
    input  wire logic                     i_reset_watchdog_halt_n,
    input  wire logic                     i_host_in_reset,
    input  wire logic                     i_boot_self_test_wd_load,
    input  wire logic [`FRBW_WD_W-1:0]    i_boot_self_test_wd_secs,
    input  wire logic                     i_boot_self_test_wd_enable,
    input  wire logic                     i_disable_req,
    input  wire logic [`FRBW_PIDX_W-1:0]  i_disable_idx,
    input  wire logic [`FRBW_NPROC-1:0]   i_proc_present,
    input  wire logic                     i_set_time,
    input  wire logic [`FRBW_TS_W-1:0]    i_set_time_val,
    input  wire logic                     i_get_time,
    input  wire logic [`FRBW_TS_W-1:0]    i_rtc_time,
    input  wire logic                     i_rtc_valid,
    output logic                          o_rtc_read,
    output logic                          o_get_time_valid,
    output logic [`FRBW_TS_W-1:0]         o_time,
    output logic [`FRBW_NPROC-1:0]        o_proc_disable,
    output logic [`FRBW_PIDX_W-1:0]       o_bootstrap_processor,
    output logic                          o_system_reset,
    output logic                          o_async_system_reset,
    output logic                          o_speaker,
    output logic                          o_halt
);
    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and tick.

    // Two-stage synchronisers for pin-level inputs.
    logic [1:0] halt_sync;
    logic [1:0] hrst_sync;
    // Once-per-second enable pulse.
    logic       tick;

    // Pins from the host pass two flops before use.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            halt_sync <= 2'h3;
            hrst_sync <= 2'h3;
        end else begin
            halt_sync <= {halt_sync[0], i_reset_watchdog_halt_n};
            hrst_sync <= {hrst_sync[0], i_host_in_reset};
        end
    end

    // Synchronised levels, read only from the second stage.
    logic halt_n_s;
    logic hrst_s;
    assign halt_n_s = halt_sync[1];
    assign hrst_s   = hrst_sync[1];

    // Shared one-second divider.
    frbw_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_RST),
        .o_tick (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Hard-reset tracking and watchdogs.

    // Previous synchronised host reset, used to spot the release edge.
    logic hrst_d;
    // One cycle after the host leaves hard reset.
    logic hrst_exit;
    // Reset-stage watchdog armed until the host halts it or re-enters hard reset.
    logic rst_wd_armed;
    logic rst_wd_exp;
    logic boot_self_test_wd_exp;

    // Remember the previous host reset level.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            hrst_d <= 1'b1;
        end else begin
            hrst_d <= hrst_s;
        end
    end

    assign hrst_exit = hrst_d && !hrst_s;

    // R1: arm at reset exit
    // The reset-stage watchdog arms on every hard-reset exit and holds armed until halted or the host re-enters hard reset.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST || hrst_s) begin
            rst_wd_armed <= 1'b0;
        end else if (hrst_exit) begin
            rst_wd_armed <= 1'b1;
        end else if (!halt_n_s) begin
            // R2: host halt line
            rst_wd_armed <= 1'b0;
        end
    end

    // Reset-stage watchdog, loaded with its nominal timeout at each reset exit.
    frbw_wd u_rst_wd (
        .i_clk      (I_CORE_CLK),
        .i_rst      (I_RST),
        .i_tick     (tick),
        .i_load     (hrst_exit),
        .i_load_val (`FRBW_WD_W'(`FRBW_RST_WD_SEC)),
        .i_enable   (rst_wd_armed),
        .o_expire   (rst_wd_exp),
        .o_count    ()
    );

    // Self-test-stage watchdog; the host picks the load value and the enable.
    frbw_wd u_boot_self_test_wd (
        .i_clk      (I_CORE_CLK),
        .i_rst      (I_RST),
        .i_tick     (tick),
        .i_load     (i_boot_self_test_wd_load),
        .i_load_val (i_boot_self_test_wd_secs),
        .i_enable   (i_boot_self_test_wd_enable && !hrst_s),
        .o_expire   (boot_self_test_wd_exp),
        .o_count    ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Processor disable and bootstrap selection.

    // Lowest present and enabled processor, or none.
    function automatic logic [`FRBW_PIDX_W:0] first_good(input logic [`FRBW_NPROC-1:0] good);
        logic [`FRBW_PIDX_W:0] r;
        r = {1'b1, `FRBW_PIDX_W'(0)};
        for (int k = `FRBW_NPROC - 1; k >= 0; k--) begin
            if (good[k]) begin
                r = {1'b0, `FRBW_PIDX_W'(k)};
            end
        end
        return r;
    endfunction

    // Current processor state and sequencer.
    frbw_pkg::frbw_state_t     state;
    logic [`FRBW_NPROC-1:0]    next_disable;
    logic [`FRBW_PIDX_W:0]     pick;
    logic [4:0]                pulse_cnt;
    logic                      fail_evt;

    // A failure event: reset-stage expiry or a host disable request.
    assign fail_evt = rst_wd_exp || i_disable_req;

    // Disable mask after the pending event is applied.
    always_comb begin
        next_disable = o_proc_disable;
        // R3: drop failed bootstrap
        if (rst_wd_exp) begin
            next_disable[o_bootstrap_processor] = 1'b1;
        end
        // R12: host disable request
        if (i_disable_req) begin
            next_disable[i_disable_idx] = 1'b1;
        end
    end

    assign pick = first_good(i_proc_present & ~next_disable);

    // R6: fresh cycling per reset
    // Supervisor reset clears the disable mask so every processor is tried again.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            o_proc_disable        <= '0;
            o_bootstrap_processor <= '0;
            state                 <= frbw_pkg::ST_RUN;
            pulse_cnt             <= 5'h0;
        end else begin
            unique case (state)
                frbw_pkg::ST_RUN: begin
                    if (fail_evt && state == frbw_pkg::ST_RUN) begin
                        o_proc_disable <= next_disable;
                        // R13: halt or transfer
                        if (pick[`FRBW_PIDX_W]) begin
                            // R5: no good processor
                            state <= frbw_pkg::ST_HALT;
                        end else begin
                            // R4: rotate bootstrap role
                            o_bootstrap_processor <= pick[`FRBW_PIDX_W-1:0];
                            state                 <= frbw_pkg::ST_RESET;
                            pulse_cnt             <= 5'(`FRBW_RST_PULSE_CYC - 1);
                        end
                    end
                end
                frbw_pkg::ST_RESET: begin
                    // Hold the system reset for a fixed pulse.
                    if (pulse_cnt == 5'h0) begin
                        state <= frbw_pkg::ST_RUN;
                    end else begin
                        pulse_cnt <= pulse_cnt - 5'h1;
                    end
                end
                frbw_pkg::ST_HALT: begin
                    // Halted until the supervisor itself is reset.
                    state <= frbw_pkg::ST_HALT;
                end
                default: begin
                    state <= frbw_pkg::ST_RUN;
                end
            endcase
        end
    end

    // R3: system reset pulse
    assign o_system_reset = (state == frbw_pkg::ST_RESET);
    assign o_halt         = (state == frbw_pkg::ST_HALT);

    // R11: async reset on expiry
    // A self-test expiry stretches to the same pulse length on its own output.
    logic [4:0] asr_cnt;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            asr_cnt <= 5'h0;
        end else if (boot_self_test_wd_exp) begin
            asr_cnt <= 5'(`FRBW_RST_PULSE_CYC);
        end else if (asr_cnt != 5'h0) begin
            asr_cnt <= asr_cnt - 5'h1;
        end
    end
    assign o_async_system_reset = (asr_cnt != 5'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // Beeper for the halted state.

    // Beep cadence counter; the speaker toggles between on and off phases.
    logic [22:0] beep_cnt;

    // R5: beep while halted
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST || !o_halt) begin
            beep_cnt  <= 23'h0;
            o_speaker <= 1'b0;
        end else if (beep_cnt == 23'h0) begin
            o_speaker <= !o_speaker;
            beep_cnt  <= o_speaker ? 23'(BEEP_OFF_CYC - 1) : 23'(BEEP_ON_CYC - 1);
        end else begin
            beep_cnt <= beep_cnt - 23'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timestamp counter.

    // Seconds until the next RTC re-read.
    logic [6:0] resync_cnt;
    // Set until the first RTC value arrives after startup.
    logic       rtc_wait;

    // R16: RTC read requests
    // A read is requested at startup and again every resync period.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            resync_cnt <= 7'h0;
            o_rtc_read <= 1'b0;
            rtc_wait   <= 1'b1;
        end else begin
            o_rtc_read <= 1'b0;
            if (i_rtc_valid) begin
                rtc_wait <= 1'b0;
            end
            if (rtc_wait && !o_rtc_read && resync_cnt == 7'h0) begin
                o_rtc_read <= 1'b1;
                resync_cnt <= 7'(`FRBW_RTC_RESYNC_SEC);
            end else if (tick) begin
                if (resync_cnt <= 7'h1) begin
                    o_rtc_read <= 1'b1;
                    resync_cnt <= 7'(`FRBW_RTC_RESYNC_SEC);
                end else begin
                    resync_cnt <= resync_cnt - 7'h1;
                end
            end
        end
    end

    // R14: once-per-second count
    // Host set wins over RTC load, which wins over the tick increment.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            o_time <= '0;
        end else if (i_set_time) begin
            // R15: set-time load
            o_time <= i_set_time_val;
        end else if (i_rtc_valid) begin
            // R16: RTC resync
            o_time <= i_rtc_time;
        end else if (tick) begin
            o_time <= o_time + `FRBW_TS_W'(1);
        end
    end

    // R15: get-time answer
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            o_get_time_valid <= 1'b0;
        end else begin
            o_get_time_valid <= i_get_time;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_EXPIRE_RESETS: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R3
        (rst_wd_exp && state == frbw_pkg::ST_RUN && !pick[`FRBW_PIDX_W]) |=> o_system_reset && pulse_cnt == 5'hf)
        else $error("Reset-stage expiry gave no reset pulse.");
    AST_PULSE_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R3
        (o_system_reset && pulse_cnt != 5'h0) |=> o_system_reset) else $error("Reset pulse cut short.");
    AST_DISABLE_FAILED: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R3
        (rst_wd_exp && state == frbw_pkg::ST_RUN) |=> o_proc_disable[$past(o_bootstrap_processor)])
        else $error("Failed bootstrap processor not disabled.");
    AST_ROTATE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R4
        $changed(o_bootstrap_processor) |-> o_system_reset)
        else $error("Bootstrap role moved without a system reset.");
    AST_HALT_BEEP: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R5
        $rose(o_halt) |-> ##1 o_speaker)
        else $error("Halt did not start beeping.");
    AST_ASR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R11
        boot_self_test_wd_exp |=> o_async_system_reset [*8])
        else $error("Self-test expiry gave no async reset.");
    AST_REQ_DISABLE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R12
        (i_disable_req && state == frbw_pkg::ST_RUN) |=> (o_proc_disable[$past(i_disable_idx)] && (o_system_reset || o_halt)))
        else $error("Disable request not acted on.");
    AST_TS_TICK: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R14
        (tick && !i_set_time && !i_rtc_valid) |=> o_time == $past(o_time) + 32'h1)
        else $error("Timestamp did not advance on the tick.");
    AST_TS_SET: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R15
        i_set_time |=> o_time == $past(i_set_time_val))
        else $error("Set-time value not loaded.");
    AST_HALT_STUCK: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R13
        o_halt |=> o_halt && !o_system_reset)
        else $error("Halt state left without reset.");

    COV_ROTATE: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) rst_wd_exp ##[1:40] o_system_reset);
    COV_HALT: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) $rose(o_halt));
    COV_ASR: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) $rose(o_async_system_reset));
    COV_SET: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) i_set_time ##1 tick);
endmodule

// file: verilog/frbw_wd.sv
// One-second watchdog counter with a single expiry pulse.
`timescale 1ns/1ns
`include "frbw_cfg.svh"

module frbw_wd (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_tick,
    input  wire logic                   i_load,
    input  wire logic [`FRBW_WD_W-1:0]  i_load_val,
    input  wire logic                   i_enable,
    output logic                        o_expire,
    output logic [`FRBW_WD_W-1:0]       o_count
);
    // Set once this arming has expired so the pulse fires only once.
    logic fired;

    // R17: tick-driven countdown
    // Loading rearms; counting stops while disabled; the expiry is one cycle wide.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_count  <= '0;
            fired    <= 1'b0;
            o_expire <= 1'b0;
        end else begin
            o_expire <= 1'b0;
            if (i_load) begin
                o_count <= i_load_val;
                fired   <= 1'b0;
            end else if (i_enable && !fired && i_tick) begin
                if (o_count <= `FRBW_WD_W'(1)) begin
                    o_count  <= '0;
                    fired    <= 1'b1;
                    o_expire <= 1'b1;
                end else begin
                    o_count <= o_count - `FRBW_WD_W'(1);
                end
            end
        end
    end

    // R17: single expiry pulse
    AST_WD_ONE_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_expire |=> !o_expire) else $error("Watchdog expiry lasted more than one cycle."); // R17
endmodule
